/* core/cmrd_ctl.sv */
// Purpose: control register of the common-mode, reference drive, common electrode and shield drive
// Assumes: single clock, plain strobe register port, read data one cycle after the read strobe
// Notes: every switch and enable output is a flip-flop loaded from the decode of the next control word
//
// Contract
// - five electrode select bits each decide independently whether that electrode joins the averaged common mode.
// - while the external common-mode source is selected the five electrode select bits are ignored.
// - with exactly one electrode selected the common mode is that electrode alone.
// - with no electrode selected the internal fixed reference becomes the common mode.
// - six switch bits connect LA, LL, RA, V1, V2 and the common electrode to the leg drive summing junction.
// - turning the leg drive off does not open the summing switches; software clears them itself.
// - one bit enables the common electrode reference and resets to off.
// - the four-bit drive select maps 0 to the dedicated output, 1 to 5 to LA, LL, RA, V1, V2; 6 to 15 are reserved.
// - the common-mode output bit drives the derived common mode onto its pin, without effect when external is chosen.
// - the source bit selects the external common mode and opens the five common-mode electrode switches; reset picks internal.
// - the leg drive enable bit turns the reference electrode drive on and resets to off.
// - the shield drive enable bit turns the shield driver on and resets to off.
// - the control word sits at register 0x05 and resets to 0xE00000.
`timescale 1ns/1ns
module cmrd_ctl #(
  parameter int ADDR_W = cmrd_pkg::ADDR_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [23:0] rdata_o,
  output logic left_arm_cm_select_o,
  output logic left_leg_cm_select_o,
  output logic right_arm_cm_select_o,
  output logic chest1_cm_select_o,
  output logic chest2_cm_select_o,
  output logic internal_cm_reference_o,
  output logic common_mode_single_o,
  output logic common_mode_average_o,
  output logic external_cm_source_select_o,
  output logic cm_output_drive_o,
  output logic left_arm_drive_sum_switch_o,
  output logic left_leg_drive_sum_switch_o,
  output logic right_arm_drive_sum_switch_o,
  output logic chest1_drive_sum_switch_o,
  output logic chest2_drive_sum_switch_o,
  output logic common_electrode_drive_sum_switch_o,
  output logic common_electrode_ref_enable_o,
  output logic [5:0] reference_drive_target_o,
  output logic reference_drive_reserved_o,
  output logic leg_drive_enable_o,
  output logic shield_driver_enable_o
);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < cmrd_pkg::ADDR_W) begin : g_addr_check
    $error("address width too small for the register map");
  end

  // ==========================================================
  // declarations
  logic [23:0] ctrl;
  logic [23:0] next_ctrl;
  logic ctrl_hit;
  logic stat_hit;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_stat;
  logic unmapped;
  logic [4:0] next_cm_sel;
  logic [4:0] next_cm_switch;
  cmrd_pkg::cmrd_cm_src_t next_cm_src;
  cmrd_pkg::cmrd_cm_src_t cm_src;
  logic [2:0] next_cm_count;
  logic [2:0] cm_count;
  logic next_cm_pin_drive;
  logic [5:0] next_ref_target;
  logic next_ref_reserved;
  logic [5:0] next_sum_switch;
  logic stale_sum;
  logic rsvd_seen;
  logic unmapped_seen;
  logic [23:0] stat_word;

  // ==========================================================
  // address decode
  assign ctrl_hit = (addr_i == ADDR_W'(cmrd_pkg::CTRL_ADDR));
  assign stat_hit = (addr_i == ADDR_W'(cmrd_pkg::STAT_ADDR));
  assign wr_ctrl = wr_i & ctrl_hit;
  assign rd_ctrl = rd_i & ctrl_hit;
  assign rd_stat = rd_i & stat_hit;
  // status is read-only, so a write to it counts as unmapped too
  assign unmapped = (wr_i & ~ctrl_hit) | (rd_i & ~ctrl_hit & ~stat_hit);

  // ==========================================================
  // control word
  // reserved bits are forced to zero on the way in so they read back zero
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = wdata_i & cmrd_pkg::CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= cmrd_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================
  // decode of the next control word
  // decoding the next word rather than the stored one lets every output
  // switch on the same edge as the register, so no mixed state is seen
  assign next_cm_sel = next_ctrl[cmrd_pkg::CM_SEL_LSB +: cmrd_pkg::CM_SEL_W];
  assign next_sum_switch = next_ctrl[cmrd_pkg::SUM_LSB +: cmrd_pkg::SUM_W];

  cmrd_cm_route u_cm_route (
    .cm_sel_i(next_cm_sel),
    .ext_sel_i(next_ctrl[cmrd_pkg::EXT_CM_BIT]),
    .cm_drive_i(next_ctrl[cmrd_pkg::CM_DRV_BIT]),
    .cm_switch_o(next_cm_switch),
    .cm_src_o(next_cm_src),
    .cm_count_o(next_cm_count),
    .cm_pin_drive_o(next_cm_pin_drive)
  );

  cmrd_ref_route u_ref_route (
    .ref_code_i(next_ctrl[cmrd_pkg::REF_SEL_LSB +: cmrd_pkg::REF_SEL_W]),
    .ref_target_o(next_ref_target),
    .ref_reserved_o(next_ref_reserved)
  );

  // ==========================================================
  // common-mode electrode switches
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_arm_cm_select_o <= 1'b1;
      left_leg_cm_select_o <= 1'b1;
      right_arm_cm_select_o <= 1'b1;
      chest1_cm_select_o <= 1'b0;
      chest2_cm_select_o <= 1'b0;
    end else begin
      left_arm_cm_select_o <= next_cm_switch[4];
      left_leg_cm_select_o <= next_cm_switch[3];
      right_arm_cm_select_o <= next_cm_switch[2];
      chest1_cm_select_o <= next_cm_switch[1];
      chest2_cm_select_o <= next_cm_switch[0];
    end
  end

  // ==========================================================
  // common-mode source
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cm_src <= cmrd_pkg::CMRD_SRC_AVERAGE;
      cm_count <= 3'h3;
    end else begin
      cm_src <= next_cm_src;
      cm_count <= next_cm_count;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      internal_cm_reference_o <= 1'b0;
      common_mode_single_o <= 1'b0;
      common_mode_average_o <= 1'b1;
      external_cm_source_select_o <= 1'b0;
    end else begin
      internal_cm_reference_o <= (next_cm_src == cmrd_pkg::CMRD_SRC_INTERNAL_REF);
      common_mode_single_o <= (next_cm_src == cmrd_pkg::CMRD_SRC_SINGLE);
      common_mode_average_o <= (next_cm_src == cmrd_pkg::CMRD_SRC_AVERAGE);
      external_cm_source_select_o <= next_ctrl[cmrd_pkg::EXT_CM_BIT];
    end
  end

  // ==========================================================
  // common-mode pin drive
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cm_output_drive_o <= 1'b0;
    end else begin
      cm_output_drive_o <= next_cm_pin_drive;
    end
  end

  // ==========================================================
  // leg drive summing junction
  // the leg drive enable deliberately does not gate these switches;
  // a disabled amplifier with closed switches is legal and flagged below
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_arm_drive_sum_switch_o <= 1'b0;
      left_leg_drive_sum_switch_o <= 1'b0;
      right_arm_drive_sum_switch_o <= 1'b0;
      chest1_drive_sum_switch_o <= 1'b0;
      chest2_drive_sum_switch_o <= 1'b0;
      common_electrode_drive_sum_switch_o <= 1'b0;
    end else begin
      left_arm_drive_sum_switch_o <= next_sum_switch[5];
      left_leg_drive_sum_switch_o <= next_sum_switch[4];
      right_arm_drive_sum_switch_o <= next_sum_switch[3];
      chest1_drive_sum_switch_o <= next_sum_switch[2];
      chest2_drive_sum_switch_o <= next_sum_switch[1];
      common_electrode_drive_sum_switch_o <= next_sum_switch[0];
    end
  end

  // ==========================================================
  // common electrode reference
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      common_electrode_ref_enable_o <= 1'b0;
    end else begin
      common_electrode_ref_enable_o <= next_ctrl[cmrd_pkg::CE_EN_BIT];
    end
  end

  // ==========================================================
  // reference drive electrode
  // a reserved code leaves every target off rather than guessing one
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reference_drive_target_o <= 6'h01;
      reference_drive_reserved_o <= 1'b0;
    end else begin
      reference_drive_target_o <= next_ref_target;
      reference_drive_reserved_o <= next_ref_reserved;
    end
  end

  // ==========================================================
  // leg drive and shield enables
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      leg_drive_enable_o <= 1'b0;
      shield_driver_enable_o <= 1'b0;
    end else begin
      leg_drive_enable_o <= next_ctrl[cmrd_pkg::RLD_EN_BIT];
      shield_driver_enable_o <= next_ctrl[cmrd_pkg::SHLD_EN_BIT];
    end
  end

  // ==========================================================
  // status flags
  // summing switches left closed while the leg drive is off: a reminder
  // for software, which must open them itself
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stale_sum <= 1'b0;
    end else begin
      stale_sum <= ~next_ctrl[cmrd_pkg::RLD_EN_BIT] & (|next_sum_switch);
    end
  end

  // sticky flags clear on a status read; a new event in that cycle wins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsvd_seen <= 1'b0;
    end else if (wr_ctrl && next_ref_reserved) begin
      rsvd_seen <= 1'b1;
    end else if (rd_stat) begin
      rsvd_seen <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unmapped_seen <= 1'b0;
    end else if (unmapped) begin
      unmapped_seen <= 1'b1;
    end else if (rd_stat) begin
      unmapped_seen <= 1'b0;
    end
  end

  always_comb begin
    stat_word = 24'h00_0000;
    stat_word[cmrd_pkg::ST_SRC_LSB +: 2] = cm_src;
    stat_word[cmrd_pkg::ST_COUNT_LSB +: 3] = cm_count;
    stat_word[cmrd_pkg::ST_REF_RSVD_BIT] = reference_drive_reserved_o;
    stat_word[cmrd_pkg::ST_STALE_SUM_BIT] = stale_sum;
    stat_word[cmrd_pkg::ST_RSVD_SEEN_BIT] = rsvd_seen;
    stat_word[cmrd_pkg::ST_UNMAPPED_BIT] = unmapped_seen;
  end

  // ==========================================================
  // read data
  // data stand only in the cycle after the strobe; idle and unmapped read zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 24'h00_0000;
    end else if (rd_ctrl) begin
      rdata_o <= ctrl;
    end else if (rd_stat) begin
      rdata_o <= stat_word;
    end else begin
      rdata_o <= 24'h00_0000;
    end
  end

endmodule : cmrd_ctl

/* inc/cmrd_pkg.sv */
// Purpose: shared constants and types of the common-mode / reference / shield drive control block
// Assumes: one 24-bit control word at a fixed register index, plain strobe bus
// Notes: all field positions and the control word reset value live here; the output flop reset values are literals in cmrd_ctl
package cmrd_pkg;

  // ==========================================================
  // bus geometry and addresses
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 6'h05;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 6'h3F;

  // ==========================================================
  // control word layout
  localparam logic [DATA_W-1:0] CTRL_RESET = 24'hE0_0000;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 24'hF8_7FFF;
  localparam int CM_SEL_LSB = 19;
  localparam int CM_SEL_W = 5;
  localparam int SUM_LSB = 9;
  localparam int SUM_W = 6;
  localparam int CE_EN_BIT = 8;
  localparam int REF_SEL_LSB = 4;
  localparam int REF_SEL_W = 4;
  localparam int CM_DRV_BIT = 3;
  localparam int EXT_CM_BIT = 2;
  localparam int RLD_EN_BIT = 1;
  localparam int SHLD_EN_BIT = 0;

  // ==========================================================
  // reference drive codes
  localparam logic [3:0] REF_DEDICATED = 4'h0;
  localparam logic [3:0] REF_LAST_ELECTRODE = 4'h5;
  localparam int REF_TARGETS = 6;

  // ==========================================================
  // status word layout
  localparam int ST_SRC_LSB = 0;
  localparam int ST_COUNT_LSB = 2;
  localparam int ST_REF_RSVD_BIT = 5;
  localparam int ST_STALE_SUM_BIT = 6;
  localparam int ST_RSVD_SEEN_BIT = 7;
  localparam int ST_UNMAPPED_BIT = 8;

  typedef enum logic [1:0] {
    CMRD_SRC_INTERNAL_REF,
    CMRD_SRC_SINGLE,
    CMRD_SRC_AVERAGE,
    CMRD_SRC_EXTERNAL
  } cmrd_cm_src_t;

  function automatic logic [2:0] cmrd_count_ones(input logic [CM_SEL_W-1:0] bits);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < CM_SEL_W; i++) begin
      n = n + {2'b00, bits[i]};
    end
    return n;
  endfunction : cmrd_count_ones

endpackage : cmrd_pkg

/* core/cmrd_cm_route.sv */
// Purpose: decode of the common-mode electrode selection and source
// Assumes: purely combinational, caller registers the results
// Notes: external source opens every internal common-mode switch
`timescale 1ns/1ns
module cmrd_cm_route (
  input wire logic [4:0] cm_sel_i,
  input wire logic ext_sel_i,
  input wire logic cm_drive_i,
  output logic [4:0] cm_switch_o,
  output cmrd_pkg::cmrd_cm_src_t cm_src_o,
  output logic [2:0] cm_count_o,
  output logic cm_pin_drive_o
);

  // ==========================================================
  // source and switch decode
  always_comb begin
    cm_count_o = cmrd_pkg::cmrd_count_ones(cm_sel_i);
    if (ext_sel_i) begin
      cm_switch_o = 5'h00;
      cm_src_o = cmrd_pkg::CMRD_SRC_EXTERNAL;
      cm_pin_drive_o = 1'b0;
    end else begin
      cm_switch_o = cm_sel_i;
      cm_pin_drive_o = cm_drive_i;
      unique case (cm_count_o)
        3'h0: cm_src_o = cmrd_pkg::CMRD_SRC_INTERNAL_REF;
        3'h1: cm_src_o = cmrd_pkg::CMRD_SRC_SINGLE;
        default: cm_src_o = cmrd_pkg::CMRD_SRC_AVERAGE;
      endcase
    end
  end

endmodule : cmrd_cm_route

/* core/cmrd_ref_route.sv */
// Purpose: decode of the reference drive electrode select code
// Assumes: purely combinational, caller registers the results
// Notes: bit 0 of the one-hot is the dedicated drive output
`timescale 1ns/1ns
module cmrd_ref_route (
  input wire logic [3:0] ref_code_i,
  output logic [5:0] ref_target_o,
  output logic ref_reserved_o
);

  // ==========================================================
  // one-hot decode; reserved codes select nothing
  always_comb begin
    ref_target_o = 6'h00;
    ref_reserved_o = 1'b0;
    if (ref_code_i <= cmrd_pkg::REF_LAST_ELECTRODE) begin
      ref_target_o[ref_code_i[2:0]] = 1'b1;
    end else begin
      ref_reserved_o = 1'b1;
    end
  end

endmodule : cmrd_ref_route

/* bench/cmrd_ctl_assertions.sv */
// Purpose: concurrent checks on the ports of the control register block
// Assumes: one clock, async active-low reset, plain strobe register port
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
module cmrd_ctl_assertions #(
  parameter int ADDR_W = cmrd_pkg::ADDR_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [23:0] rdata_o,
  input wire logic left_arm_cm_select_o,
  input wire logic left_leg_cm_select_o,
  input wire logic right_arm_cm_select_o,
  input wire logic chest1_cm_select_o,
  input wire logic chest2_cm_select_o,
  input wire logic internal_cm_reference_o,
  input wire logic common_mode_single_o,
  input wire logic common_mode_average_o,
  input wire logic external_cm_source_select_o,
  input wire logic cm_output_drive_o,
  input wire logic left_arm_drive_sum_switch_o,
  input wire logic left_leg_drive_sum_switch_o,
  input wire logic right_arm_drive_sum_switch_o,
  input wire logic chest1_drive_sum_switch_o,
  input wire logic chest2_drive_sum_switch_o,
  input wire logic common_electrode_drive_sum_switch_o,
  input wire logic common_electrode_ref_enable_o,
  input wire logic [5:0] reference_drive_target_o,
  input wire logic reference_drive_reserved_o,
  input wire logic leg_drive_enable_o,
  input wire logic shield_driver_enable_o
);
  // ==========================================================
  // grouping
  wire logic [4:0] cm_sel = {left_arm_cm_select_o, left_leg_cm_select_o, right_arm_cm_select_o,
    chest1_cm_select_o, chest2_cm_select_o};
  wire logic [5:0] sums = {left_arm_drive_sum_switch_o, left_leg_drive_sum_switch_o, right_arm_drive_sum_switch_o,
    chest1_drive_sum_switch_o, chest2_drive_sum_switch_o, common_electrode_drive_sum_switch_o};
  wire logic [25:0] all_out = {cm_sel, internal_cm_reference_o, common_mode_single_o, common_mode_average_o,
    external_cm_source_select_o, cm_output_drive_o, sums, common_electrode_ref_enable_o,
    reference_drive_target_o, reference_drive_reserved_o, leg_drive_enable_o, shield_driver_enable_o};

  function automatic logic [5:0] ref_onehot(input logic [3:0] c);
    return (c <= 4'h5) ? (6'h01 << c) : 6'h00;
  endfunction : ref_onehot

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence ctrl_wr;
    wr_i && addr_i == cmrd_pkg::CTRL_ADDR;
  endsequence
  sequence ctrl_rd;
    rd_i && addr_i == cmrd_pkg::CTRL_ADDR;
  endsequence

  // ==========================================================
  // assertions
  cm_select_a: assert property (ctrl_wr |=> cm_sel == ($past(wdata_i[23:19]) & {5{!$past(wdata_i[2])}}))
    else $error("cm select outputs differ from written word");
  single_src_a: assert property (ctrl_wr ##0 (!wdata_i[2] && $onehot(wdata_i[23:19])) |=>
    common_mode_single_o && !common_mode_average_o && !internal_cm_reference_o)
    else $error("single electrode source not flagged");
  internal_ref_a: assert property (ctrl_wr ##0 (!wdata_i[2] && wdata_i[23:19] == 5'h00) |=>
    internal_cm_reference_o && !common_mode_single_o && !common_mode_average_o)
    else $error("internal reference not chosen with no electrode");
  sum_switch_a: assert property (ctrl_wr |=> sums == $past(wdata_i[14:9]))
    else $error("sum switches differ from written word");
  ce_enable_a: assert property (ctrl_wr |=> common_electrode_ref_enable_o == $past(wdata_i[8]))
    else $error("common electrode enable differs");
  ref_decode_a: assert property (ctrl_wr |=> reference_drive_target_o == ref_onehot($past(wdata_i[7:4]))
    && reference_drive_reserved_o == ($past(wdata_i[7:4]) > 4'h5))
    else $error("drive select decode wrong");
  cm_drive_a: assert property (ctrl_wr |=> cm_output_drive_o == ($past(wdata_i[3]) && !$past(wdata_i[2]))
    && external_cm_source_select_o == $past(wdata_i[2]))
    else $error("cm drive or source select wrong");
  drive_enables_a: assert property (ctrl_wr |=> leg_drive_enable_o == $past(wdata_i[1])
    && shield_driver_enable_o == $past(wdata_i[0]))
    else $error("leg or shield enable wrong");
  outputs_hold_a: assert property (!(wr_i && addr_i == cmrd_pkg::CTRL_ADDR) |=> $stable(all_out))
    else $error("outputs moved without a control write");
  readback_a: assert property (ctrl_wr ##1 !wr_i ##1 ctrl_rd |=>
    rdata_o == ($past(wdata_i, 3) & cmrd_pkg::CTRL_WR_MASK))
    else $error("control read back wrong");
endmodule : cmrd_ctl_assertions

bind cmrd_ctl cmrd_ctl_assertions #(.ADDR_W(ADDR_W)) i_chk (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .left_arm_cm_select_o, .left_leg_cm_select_o, .right_arm_cm_select_o, .chest1_cm_select_o,
  .chest2_cm_select_o, .internal_cm_reference_o, .common_mode_single_o, .common_mode_average_o,
  .external_cm_source_select_o, .cm_output_drive_o, .left_arm_drive_sum_switch_o, .left_leg_drive_sum_switch_o,
  .right_arm_drive_sum_switch_o, .chest1_drive_sum_switch_o, .chest2_drive_sum_switch_o,
  .common_electrode_drive_sum_switch_o, .common_electrode_ref_enable_o, .reference_drive_target_o,
  .reference_drive_reserved_o, .leg_drive_enable_o, .shield_driver_enable_o);

/* bench/test_common_mode_ref_drive_ctl.sv */
// Purpose: self-checking bench of the control register block
// Assumes: plain strobe bus, read data one cycle after the strobe
// Notes: every control write is followed by a compare of all decoded outputs
`timescale 1ns/1ns
module test_common_mode_ref_drive_ctl;
  logic clock_i;
  logic nrst_i;
  logic [5:0] addr_i;
  logic [23:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [23:0] rdata_o;
  logic [25:0] outs;
  logic [23:0] v;
  int err_count;
  int num_checks;
  int cyc = 0;

  cmrd_ctl i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .left_arm_cm_select_o(outs[25]), .left_leg_cm_select_o(outs[24]),
    .right_arm_cm_select_o(outs[23]), .chest1_cm_select_o(outs[22]), .chest2_cm_select_o(outs[21]),
    .internal_cm_reference_o(outs[20]), .common_mode_single_o(outs[19]), .common_mode_average_o(outs[18]),
    .external_cm_source_select_o(outs[17]), .cm_output_drive_o(outs[16]),
    .left_arm_drive_sum_switch_o(outs[15]), .left_leg_drive_sum_switch_o(outs[14]),
    .right_arm_drive_sum_switch_o(outs[13]), .chest1_drive_sum_switch_o(outs[12]),
    .chest2_drive_sum_switch_o(outs[11]), .common_electrode_drive_sum_switch_o(outs[10]),
    .common_electrode_ref_enable_o(outs[9]), .reference_drive_target_o(outs[8:3]),
    .reference_drive_reserved_o(outs[2]), .leg_drive_enable_o(outs[1]), .shield_driver_enable_o(outs[0])
  );

  // ==========================================================
  // expected outputs from a stored control word
  function automatic logic [25:0] exp_outs(input logic [23:0] w);
    logic [2:0] n;
    logic [5:0] tgt;
    n = 3'($countones(w[23:19]));
    tgt = (w[7:4] <= 4'h5) ? (6'h01 << w[7:4]) : 6'h00;
    return {w[23:19] & {5{~w[2]}}, !w[2] && n == 3'h0, !w[2] && n == 3'h1, !w[2] && n > 3'h1, w[2],
      w[3] & ~w[2], w[14:8], tgt, w[7:4] > 4'h5, w[1:0]};
  endfunction : exp_outs

  // ==========================================================
  // bus and compare tasks
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic wrc(input logic [23:0] d);
    wr(6'h05, d);
    check(outs, exp_outs(d & cmrd_pkg::CTRL_WR_MASK));
  endtask : wrc

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // hang guard: the tests need well under 1000 cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // tests
  initial begin
    nrst_i = 1'b0;
    addr_i = 6'h00;
    wdata_i = 24'h00_0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clock_i);
    // release away from the sampling edge
    @(negedge clock_i);
    nrst_i = 1'b1;
    check(outs, exp_outs(24'hE0_0000));
    rd(6'h05, v);
    check({2'b00, v}, {2'b00, 24'hE0_0000});
    $display("test reset done");
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 32; s++) begin
        wrc({5'(s), 15'h0000, 1'b1, 1'(e), 2'b00});
      end
    end
    $display("test common mode done");
    for (int c = 0; c < 16; c++) begin
      wrc({15'h0000, 1'(c), 4'(c), 4'h0});
      rd(6'h05, v);
      check({2'b00, v}, {2'b00, 15'h0000, 1'(c), 4'(c), 4'h0});
    end
    $display("test drive select done");
    wrc(24'h00_7E02);
    wrc(24'h00_7E00);
    // switches left closed with the leg drive off are flagged; reserved codes seen earlier are sticky
    rd(cmrd_pkg::STAT_ADDR, v);
    check({2'b00, v}, {2'b00, 24'h00_00C0});
    wrc(24'h00_2A01);
    $display("test leg drive done");
    wrc(24'hFF_FFFF);
    rd(6'h05, v);
    check({2'b00, v}, {2'b00, 24'hF8_7FFF});
    wr(6'h06, 24'h00_0000);
    wr(cmrd_pkg::STAT_ADDR, 24'h00_0000);
    check(outs, exp_outs(24'hF8_7FFF));
    rd(6'h06, v);
    check({2'b00, v}, 26'h000_0000);
    // sticky flags show once, then clear on the status read
    rd(cmrd_pkg::STAT_ADDR, v);
    check({2'b00, v}, {2'b00, 24'h00_01B7});
    rd(cmrd_pkg::STAT_ADDR, v);
    check({2'b00, v}, {2'b00, 24'h00_0037});
    $display("test register map done");
    // a reset in mid-run must bring every output and the status back to the reset state
    @(negedge clock_i);
    nrst_i = 1'b0;
    @(negedge clock_i);
    check(outs, exp_outs(24'hE0_0000));
    nrst_i = 1'b1;
    rd(cmrd_pkg::STAT_ADDR, v);
    check({2'b00, v}, {2'b00, 24'h00_000E});
    $display("test reset again done");
    end_sim();
  end
endmodule : test_common_mode_ref_drive_ctl
